/* src/exec_pkg.sv */
/*
 * Constants, types and register map of the instruction execution block.
 * Assumes an AXI4-Lite master with 32-bit data and 8-bit byte addresses.
 */
package exec_pkg;

	// ==========================================================
	// Register map and field layout
	localparam logic [7:0] OFS_INSTR = 8'h00;
	localparam logic [7:0] OFS_CTRL  = 8'h04;
	localparam logic [7:0] OFS_ACC   = 8'h08;
	localparam logic [7:0] OFS_PC    = 8'h0c;
	localparam logic [7:0] OFS_WDOG  = 8'h10;
	localparam int INS_DEST_BIT = 4;
	localparam int INS_FILE_LSB = 8;
	localparam int INS_LIT_LSB  = 16;
	localparam int ST_BUSY      = 0;
	localparam int ST_ASLEEP    = 1;
	localparam int ST_ZERO      = 2;
	localparam int ST_CARRY     = 3;
	localparam int ST_TIMEOUT   = 4;
	localparam int ST_PDOWN     = 5;
	localparam int ST_INT_EN    = 6;
	localparam int CTRL_WAKE    = 0;
	localparam logic [1:0] RESP_OKAY   = 2'b00;
	localparam logic [1:0] RESP_SLVERR = 2'b10;

	// ==========================================================
	// Core sizes and reset values
	localparam int PC_W        = 13;
	localparam int SP_W        = 3;
	localparam int STACK_DEPTH = 8;
	localparam int FILE_AW     = 7;
	localparam int FILE_DEPTH  = 128;
	localparam logic TIMEOUT_RST = 1'b1;
	localparam logic PDOWN_RST   = 1'b1;
	localparam logic GIE_RST     = 1'b0;
	localparam logic [7:0] WDOG_CLR    = 8'h00;
	localparam logic [7:0] PRESCALE_TOP = 8'hff;

	// ==========================================================
	// Operation codes and controller states
	typedef enum logic [3:0] {
		OP_NOP    = 4'h0,
		OP_MOVE   = 4'h1,
		OP_RLC    = 4'h2,
		OP_RRC    = 4'h3,
		OP_RETURN = 4'h4,
		OP_RETLIT = 4'h5,
		OP_RETINT = 4'h6,
		OP_SLEEP  = 4'h7,
		OP_CALL   = 4'h8,
		OP_LOADF  = 4'h9
	} op_t;

	typedef enum logic [2:0] {
		S_IDLE  = 3'b001,
		S_FLUSH = 3'b010,
		S_SLEEP = 3'b100
	} state_t;

endpackage

/* src/exec_alu_if.sv */
/*
 * Interface between the execution controller and its datapath.
 * Assumes both ends sit in the same clock domain; it is purely combinational.
 */
`timescale 1ns/1ps
`default_nettype none
interface exec_alu_if;
	logic [3:0] op;
	logic [7:0] operand;
	logic       carryIn;
	logic [7:0] result;
	logic       carryOut;
	logic       zeroOut;

	modport core (output op, output operand, output carryIn,
		input result, input carryOut, input zeroOut);
	modport alu (input op, input operand, input carryIn,
		output result, output carryOut, output zeroOut);
endinterface
`default_nettype wire

/* src/exec_alu.sv */
/*
 * Combinational datapath for move and rotate-through-carry operations.
 * Assumes the controller decides where the result goes and which flags it keeps.
 */
`timescale 1ns/1ps
`default_nettype none
module exec_alu
	import exec_pkg::*;
(
	exec_alu_if.alu bus
);
	// ==========================================================
	// Result and flag generation
	// Carry passes through untouched for anything that is not a rotate.
	always_comb begin
		bus.result   = bus.operand;
		bus.carryOut = bus.carryIn;
		case (bus.op)
			OP_RLC: begin
				bus.result   = {bus.operand[6:0], bus.carryIn};
				bus.carryOut = bus.operand[7];
			end
			OP_RRC: begin
				bus.result   = {bus.carryIn, bus.operand[7:1]};
				bus.carryOut = bus.operand[0];
			end
			default: begin
				bus.result   = bus.operand;
				bus.carryOut = bus.carryIn;
			end
		endcase
		bus.zeroOut = (bus.result == 8'h00);
	end
endmodule
`default_nettype wire

/* src/exec_core.sv */
/*
 * Instruction execution block: accumulator, file registers, flags, stack,
 * watchdog and sleep state, driven by instructions written over AXI4-Lite.
 * Assumes a single 200 MHz clock, one instruction cycle per clock.
 */
`timescale 1ns/1ps
`default_nettype none
module exec_core
	import exec_pkg::*;
(
	input  wire logic        clk,
	input  wire logic        rst_n,
	input  wire logic [7:0]  s_axi_awaddr,
	input  wire logic        s_axi_awvalid,
	output logic             s_axi_awready,
	input  wire logic [31:0] s_axi_wdata,
	input  wire logic [3:0]  s_axi_wstrb,
	input  wire logic        s_axi_wvalid,
	output logic             s_axi_wready,
	output logic [1:0]       s_axi_bresp,
	output logic             s_axi_bvalid,
	input  wire logic        s_axi_bready,
	input  wire logic [7:0]  s_axi_araddr,
	input  wire logic        s_axi_arvalid,
	output logic             s_axi_arready,
	output logic [31:0]      s_axi_rdata,
	output logic [1:0]       s_axi_rresp,
	output logic             s_axi_rvalid,
	input  wire logic        s_axi_rready
);
	// ==========================================================
	// Bus slave state
	logic        awHeld_reg, awHeld_next;
	logic        wHeld_reg, wHeld_next;
	logic [7:0]  awAddr_reg, awAddr_next;
	logic [31:0] wData_reg, wData_next;
	logic        bValid_reg, bValid_next;
	logic [1:0]  bResp_reg, bResp_next;
	logic        rValid_reg, rValid_next;
	logic [31:0] rData_reg, rData_next;
	logic [1:0]  rResp_reg, rResp_next;
	logic        writeFire, startNow, wakeNow;

	// ==========================================================
	// Core state
	state_t          state_reg, state_next;
	logic [7:0]      acc_reg, acc_next;
	logic            zero_reg, zero_next, carry_reg, carry_next;
	logic            timeout_reg, timeout_next, pdown_reg, pdown_next;
	logic            gie_reg, gie_next;
	logic [PC_W-1:0] pc_reg, pc_next;
	logic [SP_W-1:0] sp_reg, sp_next;
	logic [PC_W-1:0] stack_reg [STACK_DEPTH];
	logic [PC_W-1:0] stack_next [STACK_DEPTH];
	logic [7:0]      wdog_reg, wdog_next, presc_reg, presc_next;
	logic [7:0]      fileMem [FILE_DEPTH];
	logic            fileWe;
	logic [7:0]      fileData;
	op_t             insOp;
	logic            insDest;
	logic [6:0]      insFile;
	logic [7:0]      insLit;
	logic [PC_W-1:0] stackTop;
	exec_alu_if      aluBus ();

	exec_alu u_alu (
		.bus (aluBus.alu)
	);

	// Byte strobes mask the staged word so partial writes land as zeros.
	assign insOp    = op_t'(wData_reg[3:0]);
	assign insDest  = wData_reg[INS_DEST_BIT];
	assign insFile  = wData_reg[INS_FILE_LSB +: FILE_AW];
	assign insLit   = wData_reg[INS_LIT_LSB +: 8];
	assign stackTop = stack_reg[sp_reg - 3'd1];
	assign aluBus.op      = insOp;
	assign aluBus.operand = fileMem[insFile];
	assign aluBus.carryIn = carry_reg;

	// Write readies are combinational from the hold flags and the read ready from the read valid flop; valid, response and data outputs come from flops.
	assign s_axi_awready = !awHeld_reg;
	assign s_axi_wready  = !wHeld_reg;
	assign s_axi_bvalid  = bValid_reg;
	assign s_axi_bresp   = bResp_reg;
	assign s_axi_arready = !rValid_reg;
	assign s_axi_rvalid  = rValid_reg;
	assign s_axi_rdata   = rData_reg;
	assign s_axi_rresp   = rResp_reg;

	// A write completes once address and data are both staged and no
	// response is still waiting; an instruction written while busy is dropped.
	assign writeFire = awHeld_reg && wHeld_reg && !bValid_reg;
	assign startNow  = writeFire && (awAddr_reg == OFS_INSTR) && (state_reg == S_IDLE);
	assign wakeNow   = writeFire && (awAddr_reg == OFS_CTRL) && wData_reg[CTRL_WAKE];

	// ==========================================================
	// Bus next-state logic
	always_comb begin
		awHeld_next = awHeld_reg && !writeFire;
		wHeld_next  = wHeld_reg && !writeFire;
		awAddr_next = awAddr_reg;
		wData_next  = wData_reg;
		if (s_axi_awvalid && !awHeld_reg) begin
			awHeld_next = 1'b1;
			awAddr_next = s_axi_awaddr;
		end
		if (s_axi_wvalid && !wHeld_reg) begin
			wHeld_next = 1'b1;
			wData_next = s_axi_wdata & {{8{s_axi_wstrb[3]}}, {8{s_axi_wstrb[2]}},
				{8{s_axi_wstrb[1]}}, {8{s_axi_wstrb[0]}}};
		end
		bValid_next = writeFire || (bValid_reg && !s_axi_bready);
		bResp_next  = bResp_reg;
		if (writeFire) begin
			bResp_next = (awAddr_reg == OFS_INSTR || awAddr_reg == OFS_CTRL) ?
				RESP_OKAY : RESP_SLVERR;
		end
		rValid_next = rValid_reg && !s_axi_rready;
		rData_next  = rData_reg;
		rResp_next  = rResp_reg;
		if (s_axi_arvalid && !rValid_reg) begin
			rValid_next = 1'b1;
			rResp_next  = RESP_OKAY;
			case (s_axi_araddr)
				OFS_CTRL: rData_next = {25'h0000000, gie_reg, pdown_reg, timeout_reg,
					carry_reg, zero_reg, state_reg == S_SLEEP, state_reg != S_IDLE};
				OFS_ACC:  rData_next = {24'h000000, acc_reg};
				OFS_PC:   rData_next = {19'h00000, pc_reg};
				OFS_WDOG: rData_next = {16'h0000, presc_reg, wdog_reg};
				default: begin
					rData_next = 32'h00000000;
					rResp_next = RESP_SLVERR;
				end
			endcase
		end
	end

	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			awHeld_reg <= 1'b0;
			wHeld_reg  <= 1'b0;
			awAddr_reg <= 8'h00;
			wData_reg  <= 32'h00000000;
			bValid_reg <= 1'b0;
			bResp_reg  <= RESP_OKAY;
			rValid_reg <= 1'b0;
			rData_reg  <= 32'h00000000;
			rResp_reg  <= RESP_OKAY;
		end else begin
			awHeld_reg <= awHeld_next;
			wHeld_reg  <= wHeld_next;
			awAddr_reg <= awAddr_next;
			wData_reg  <= wData_next;
			bValid_reg <= bValid_next;
			bResp_reg  <= bResp_next;
			rValid_reg <= rValid_next;
			rData_reg  <= rData_next;
			rResp_reg  <= rResp_next;
		end
	end

	// ==========================================================
	// Core next-state logic
	// The watchdog keeps counting in sleep; it runs from clk through the prescaler.
	always_comb begin
		state_next   = state_reg;
		acc_next     = acc_reg;
		zero_next    = zero_reg;
		carry_next   = carry_reg;
		timeout_next = timeout_reg;
		pdown_next   = pdown_reg;
		gie_next     = gie_reg;
		pc_next      = pc_reg;
		sp_next      = sp_reg;
		stack_next   = stack_reg;
		fileWe       = 1'b0;
		fileData     = aluBus.result;
		presc_next   = presc_reg + 8'h01;
		wdog_next    = (presc_reg == PRESCALE_TOP) ? wdog_reg + 8'h01 : wdog_reg;
		case (state_reg)
			S_IDLE: begin
				if (startNow) begin
					pc_next = pc_reg + 13'd1;
					case (insOp)
						OP_MOVE, OP_RLC, OP_RRC: begin
							if (insDest) begin
								fileWe = 1'b1;
							end else begin
								acc_next = aluBus.result;
							end
							if (insOp == OP_MOVE) begin
								zero_next = aluBus.zeroOut;
							end else begin
								carry_next = aluBus.carryOut;
							end
						end
						OP_RETURN, OP_RETLIT, OP_RETINT: begin
							pc_next    = stackTop;
							sp_next    = sp_reg - 3'd1;
							state_next = S_FLUSH;
							if (insOp == OP_RETLIT) begin
								acc_next = insLit;
							end
							if (insOp == OP_RETINT) begin
								gie_next = 1'b1;
							end
						end
						OP_SLEEP: begin
							wdog_next    = WDOG_CLR;
							presc_next   = WDOG_CLR;
							timeout_next = 1'b1;
							pdown_next   = 1'b0;
							state_next   = S_SLEEP;
						end
						OP_CALL: begin
							stack_next[sp_reg] = pc_reg + 13'd1;
							sp_next            = sp_reg + 3'd1;
							pc_next            = {5'h00, insLit};
							state_next         = S_FLUSH;
						end
						OP_LOADF: begin
							fileWe   = 1'b1;
							fileData = insLit;
						end
						default: begin
							pc_next = pc_reg + 13'd1;
						end
					endcase
				end
			end
			S_FLUSH: state_next = S_IDLE;
			S_SLEEP: begin
				if (wakeNow) begin
					state_next = S_IDLE;
				end
			end
			default: state_next = S_IDLE;
		endcase
	end

	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			state_reg   <= S_IDLE;
			acc_reg     <= 8'h00;
			zero_reg    <= 1'b0;
			carry_reg   <= 1'b0;
			timeout_reg <= TIMEOUT_RST;
			pdown_reg   <= PDOWN_RST;
			gie_reg     <= GIE_RST;
			pc_reg      <= 13'd0;
			sp_reg      <= 3'd0;
			stack_reg   <= '{default: 13'd0};
			wdog_reg    <= WDOG_CLR;
			presc_reg   <= WDOG_CLR;
		end else begin
			state_reg   <= state_next;
			acc_reg     <= acc_next;
			zero_reg    <= zero_next;
			carry_reg   <= carry_next;
			timeout_reg <= timeout_next;
			pdown_reg   <= pdown_next;
			gie_reg     <= gie_next;
			pc_reg      <= pc_next;
			sp_reg      <= sp_next;
			stack_reg   <= stack_next;
			wdog_reg    <= wdog_next;
			presc_reg   <= presc_next;
		end
	end

	// File registers are plain storage with no reset, like real RAM.
	always_ff @(posedge clk) begin
		if (fileWe) begin
			fileMem[insFile] <= fileData;
		end
	end

	// ==========================================================
	// Checks
	default clocking cb @(posedge clk); endclocking
	default disable iff (!rst_n);

	AST_MOVE_DEST: assert property (startNow && insOp == OP_MOVE && !insDest |=>
		acc_reg == $past(aluBus.operand)) else $error("move to accumulator wrong");
	AST_MOVE_ZERO: assert property (startNow && insOp == OP_MOVE |=>
		zero_reg == ($past(aluBus.operand) == 8'h00) && $stable(carry_reg))
		else $error("move zero flag wrong");
	AST_RET_INT: assert property (startNow && insOp == OP_RETINT |=>
		gie_reg && pc_reg == $past(stackTop) && $stable(zero_reg) && $stable(carry_reg))
		else $error("interrupt return wrong");
	AST_ROT_LEFT: assert property (startNow && insOp == OP_RLC && !insDest |=>
		acc_reg == {$past(aluBus.operand[6:0]), $past(carry_reg)}
		&& carry_reg == $past(aluBus.operand[7])) else $error("rotate left wrong");
	AST_ROT_RIGHT: assert property (startNow && insOp == OP_RRC && !insDest |=>
		acc_reg == {$past(carry_reg), $past(aluBus.operand[7:1])}
		&& carry_reg == $past(aluBus.operand[0]) && $stable(zero_reg))
		else $error("rotate right wrong");
	AST_RET_LIT: assert property (startNow && insOp == OP_RETLIT |=>
		acc_reg == $past(insLit) && pc_reg == $past(stackTop)) else $error("literal return wrong");
	AST_RET_LIT_TWO: assert property (startNow && insOp == OP_RETLIT |=>
		state_reg == S_FLUSH ##1 state_reg == S_IDLE) else $error("literal return not two cycles");
	AST_RETURN: assert property (startNow && insOp == OP_RETURN |=>
		pc_reg == $past(stackTop) && sp_reg == $past(sp_reg) - 3'd1 && $stable(zero_reg))
		else $error("subroutine return wrong");
	AST_SLEEP_BITS: assert property (startNow && insOp == OP_SLEEP |=>
		wdog_reg == WDOG_CLR && presc_reg == WDOG_CLR && timeout_reg && !pdown_reg
		&& $stable(zero_reg)) else $error("sleep status wrong");
	AST_SLEEP_HOLD: assert property (state_reg == S_SLEEP && !wakeNow |=>
		state_reg == S_SLEEP) else $error("sleep state left without wake");
	AST_NOP: assert property (startNow && insOp == OP_NOP |=>
		pc_reg == $past(pc_reg) + 13'd1 && $stable(acc_reg) && state_reg == S_IDLE)
		else $error("no-operation changed state");

	COV_RET_LIT: cover property (startNow && insOp == OP_RETLIT);
	// A software wake needs a full bus write, so the window is generous.
	COV_SLEEP_WAKE: cover property (state_reg == S_SLEEP ##[1:200] state_reg == S_IDLE);
	COV_ROT_BACK: cover property (startNow && insOp == OP_RLC && insDest);
endmodule
`default_nettype wire

/* sim/test_move_rotate_return_sleep_ops.sv */
/* Self-checking bench for the instruction execution block.
   Assumes the block is reached only through its AXI4-Lite port on one 200 MHz clock. */
`timescale 1ns/1ps
`default_nettype none
`define CHK(nm, e, g) begin checkCount++; if ((g) !== (e)) begin mismatches++; \
	$display("ERROR %s expected %h seen %h", nm, e, g); end end
module test_move_rotate_return_sleep_ops;
	import exec_pkg::*;
	// ==========================================================
	// Stimulus signals and reference state
	logic        clk = 1'b0;
	logic        rst_n = 1'b0;
	logic [7:0]  awAddr = 8'h00, arAddr = 8'h00;
	// Response readies stay high, so an answer is taken at the edge it is sampled.
	logic        awValid = 1'b0, wValid = 1'b0, bReady = 1'b1, arValid = 1'b0, rReady = 1'b1;
	logic [31:0] wData = 32'h0;
	logic [3:0]  wStrb = 4'hf;
	logic        awReady, wReady, bValid, arReady, rValid;
	logic [1:0]  bResp, rResp, resp;
	logic [31:0] rData, rd;
	int          mismatches = 0, checkCount = 0, seed = 94034, sp = 0;
	logic [7:0]  acc, fm[128];
	logic        z, c, global_interrupt_enable, tob, pdb;
	logic [12:0] pc, stk[8];

	// ==========================================================
	// Clock and design
	always #2.5 clk = ~clk;
	exec_core DUT (.clk(clk), .rst_n(rst_n), .s_axi_awaddr(awAddr), .s_axi_awvalid(awValid),
		.s_axi_awready(awReady), .s_axi_wdata(wData), .s_axi_wstrb(wStrb),
		.s_axi_wvalid(wValid), .s_axi_wready(wReady), .s_axi_bresp(bResp),
		.s_axi_bvalid(bValid), .s_axi_bready(bReady), .s_axi_araddr(arAddr),
		.s_axi_arvalid(arValid), .s_axi_arready(arReady), .s_axi_rdata(rData),
		.s_axi_rresp(rResp), .s_axi_rvalid(rValid), .s_axi_rready(rReady));

	// Handshakes are judged at the falling edge so that the rising edge's own updates never race.
	task automatic axiWr(input logic [7:0] a, input logic [31:0] d, input logic [3:0] s);
		int n;
		logic aHs, wHs, bHs;
		awAddr <= a;
		awValid <= 1'b1;
		wData <= d;
		wStrb <= s;
		wValid <= 1'b1;
		n = 0;
		bHs = 1'b0;
		while (!bHs && n < 50) begin
			@(negedge clk);
			aHs = awValid && awReady;
			wHs = wValid && wReady;
			bHs = bValid;
			resp = bResp;
			@(posedge clk);
			n++;
			if (aHs) awValid <= 1'b0;
			if (wHs) wValid <= 1'b0;
		end
		if (!bHs) mismatches++;
	endtask

	// Read data is captured in the cycle where valid stands, before it may drop.
	task automatic axiRd(input logic [7:0] a);
		int n;
		logic aHs, dHs;
		arAddr <= a;
		arValid <= 1'b1;
		n = 0;
		dHs = 1'b0;
		while (!dHs && n < 50) begin
			@(negedge clk);
			aHs = arValid && arReady;
			dHs = rValid;
			rd = rData;
			resp = rResp;
			@(posedge clk);
			n++;
			if (aHs) arValid <= 1'b0;
		end
		if (!dHs) mismatches++;
	endtask

	// Compares accumulator, program counter and flags with the reference state.
	task automatic checkState(input logic sleeping);
		axiRd(OFS_ACC);
		`CHK("acc", acc, rd[7:0])
		axiRd(OFS_PC);
		`CHK("pc", pc, rd[12:0])
		axiRd(OFS_CTRL);
		// The busy bit stays up for as long as the core sleeps.
		`CHK("ctrl", {global_interrupt_enable, pdb, tob, c, z, sleeping, sleeping}, rd[6:0])
	endtask

	// Issues one instruction, waits out any branch cycle, then updates the reference.
	task automatic run(input logic [3:0] op, input logic d, input logic [6:0] f,
		input logic [7:0] k, input logic [3:0] s);
		logic [8:0] t;
		int n;
		axiWr(OFS_INSTR, {8'h00, k, 1'b0, f, 3'h0, d, op}, s);
		n = 0;
		rd = 32'h1;
		while (rd[0] !== 1'b0 && rd[1] !== 1'b1 && n < 8) begin
			axiRd(OFS_CTRL);
			n++;
		end
		if (s[2] == 1'b0) k = 8'h00;
		t = (op == 4'h2) ? {fm[f], c} : (op == 4'h3) ? {fm[f][0], c, fm[f][7:1]} : {c, fm[f]};
		pc = pc + 13'h1;
		case (op)
			4'h1, 4'h2, 4'h3: begin
				if (d) fm[f] = t[7:0]; else acc = t[7:0];
				c = t[8];
				if (op == 4'h1) z = (t[7:0] == 8'h00);
			end
			4'h4, 4'h5, 4'h6: begin
				sp--;
				pc = stk[sp];
				if (op == 4'h5) acc = k;
				if (op == 4'h6) global_interrupt_enable = 1'b1;
			end
			4'h7: begin
				tob = 1'b1;
				pdb = 1'b0;
			end
			4'h8: begin
				stk[sp] = pc;
				sp++;
				pc = {5'h00, k};
			end
			4'h9: fm[f] = k;
			default: ;
		endcase
		checkState(op == 4'h7);
	endtask

	// ==========================================================
	// Main sequence: corners first, then random traffic, then sleep.
	initial begin
		logic [3:0] op;
		acc = 8'h00;
		{z, c, global_interrupt_enable, tob, pdb, pc} = {3'b000, TIMEOUT_RST, PDOWN_RST, 13'h0};
		repeat (8) @(posedge clk);
		rst_n <= 1'b1;
		@(posedge clk);
		// All three request readies are up once reset is gone.
		`CHK("readyIdle", 3'b111, {awReady, wReady, arReady})
		checkState(1'b0);
		axiRd(8'h14);
		`CHK("unmappedResp", RESP_SLVERR, resp)
		`CHK("unmappedData", 32'h0, rd)
		axiWr(OFS_ACC, 32'h55, 4'hf);
		`CHK("roWriteResp", RESP_SLVERR, resp)
		for (int i = 0; i < 8; i++) run(4'h9, 1'b0, i[6:0], $random(seed), 4'hf);
		run(4'h9, 1'b0, 7'd127, 8'h80, 4'hf);
		run(4'h9, 1'b0, 7'd5, 8'h7e, 4'b1011);
		run(4'h1, 1'b1, 7'd5, 8'h00, 4'hf);
		run(4'h1, 1'b0, 7'd127, 8'h00, 4'hf);
		run(4'h2, 1'b1, 7'd127, 8'h00, 4'hf);
		run(4'h3, 1'b0, 7'd127, 8'h00, 4'hf);
		run(4'h8, 1'b0, 7'd0, 8'h12, 4'hf);
		run(4'h8, 1'b0, 7'd0, 8'hff, 4'hf);
		run(4'h5, 1'b0, 7'd0, 8'ha5, 4'hf);
		run(4'h6, 1'b0, 7'd0, 8'h00, 4'hf);
		run(4'h0, 1'b0, 7'd0, 8'h00, 4'hf);
		run(4'hf, 1'b0, 7'd0, 8'h00, 4'hf);
		for (int i = 0; i < 60; i++) begin
			op = $random(seed);
			if (op == 4'h7 || (op inside {[4'h4:4'h6]} && sp == 0)) op = 4'h8;
			if (op == 4'h8 && sp == 8) op = 4'h0;
			run(op, $random(seed), $random(seed) & 7, $random(seed), 4'hf);
		end
		// Sleep: watchdog cleared, status bits moved, instructions refused until woken.
		run(4'h7, 1'b0, 7'd0, 8'h00, 4'hf);
		axiRd(OFS_WDOG);
		`CHK("wdogCount", 8'h00, rd[7:0])
		`CHK("wdogPrescaleFresh", 1'b1, rd[15:8] < 8'h40)
		checkState(1'b1);
		axiWr(OFS_INSTR, 32'h00_5a_00_05, 4'hf);
		`CHK("asleepWriteResp", RESP_OKAY, resp)
		checkState(1'b1);
		axiWr(OFS_CTRL, 32'h1, 4'hf);
		checkState(1'b0);
		run(4'h1, 1'b0, 7'd127, 8'h00, 4'hf);
		summarize();
	end

	// Cuts a hang short; the full sequence needs about a thousand cycles.
	initial begin
		#200000;
		mismatches++;
		summarize();
	end

	task automatic summarize();
		$display("checks %0d mismatches %0d", checkCount, mismatches);
		if (mismatches == 0 && checkCount > 0) $display("bench passed");
		else $display("bench failed");
		$finish;
	endtask
endmodule
`default_nettype wire
